//--- conv_ctrl_map.vh
// Purpose: offsets, fields, reset values and counts of the converter control block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: included by the control block and the bench
`ifndef CONV_CTRL_MAP_VH
`define CONV_CTRL_MAP_VH
`define OFS_CONTROL_ZERO 8'h00
`define OFS_CONTROL_ONE 8'h04
`define OFS_CONTROL_TWO 8'h08
`define OFS_CLOCK_SOURCE 8'h0c
`define OFS_COMPARE_ZERO 8'h10
`define OFS_COMPARE_ONE 8'h14
`define OFS_STATUS 8'h18
`define OFS_SLOT_BASE 8'h20
`define OFS_RESULT_BASE 8'h30
// control_zero fields
`define F_POWER_POLICY 0
`define F_DIVIDER_LO 1
`define F_DIVIDER_HI 3
// control_one fields
`define F_ENABLE 0
`define F_START 1
`define F_TRIG_ORIGIN 2
`define F_SAMP_STYLE 3
// control_two field
`define F_DEPTH_LO 1
`define F_DEPTH_HI 2
// slot fields
`define F_REF_LO 0
`define F_REF_HI 1
`define F_TIME_PICK 2
// status fields
`define F_BUSY 0
`define F_MOD_EN 1
`define F_SAMPLE 2
`define RST_DEPTH 2'h0
`define RST_COMPARE 10'h000
`define CONV_CYC_12 5'h0e
`define CONV_CYC_10 5'h0c
`define CONV_CYC_8 5'h09
`define MANUAL_SYNC_CYC 2'h2
`endif

//--- result_store.v
// Purpose: four 16-bit result slots with registered read data
// Assumes: one write and one read port on aclk
// Notes: read data appear one cycle after rd_addr
`timescale 1ns/1ps
`default_nettype none
module result_store (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // write port
  input wire wr_en,
  input wire [1:0] wr_addr,
  input wire [15:0] wr_data,
  // read port
  input wire [1:0] rd_addr,
  output reg [15:0] rd_data
);
  reg [15:0] mem [0:3];
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        mem[i] <= 16'h0000;
      end
      rd_data <= 16'h0000;
    end else begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

//--- conv_ctrl.v
// Purpose: sample and conversion control for a 12-bit SAR converter
// Assumes: aclk is the selected converter clock; the far side follows the software rules
// Notes: AXI4-Lite slave; reads answer two cycles after address, writes two cycles after both
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_map.vh"
module conv_ctrl (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // event trigger and chip power state
  input wire event_trigger,
  input wire low_power_mode,
  // analog core
  output reg module_enable,
  output reg sample,
  output reg convert,
  output reg [1:0] conv_bit_depth,
  output reg [1:0] reference_pick,
  output reg [1:0] clock_origin_field,
  output reg [1:0] active_slot,
  input wire core_done,
  input wire [15:0] core_result
);
  localparam ST_IDLE = 3'h0;
  localparam ST_WAKE = 3'h1;
  localparam ST_SAMP = 3'h2;
  localparam ST_SYNC = 3'h3;
  localparam ST_CONV = 3'h4;
  localparam ST_WAIT = 3'h5;

  // registers
  reg power_policy_bit;
  reg [2:0] sample_clock_divider;
  reg conversion_enable_bit;
  reg start_conversion_bit;
  reg trigger_origin_bit;
  reg sampling_style_bit;
  reg [1:0] bit_depth_select;
  reg [9:0] compare_zero;
  reg [9:0] compare_one;
  reg [2:0] slot_cfg [0:3];
  reg [2:0] state;
  reg [9:0] sample_timer;
  reg [4:0] conv_count;
  reg [1:0] sync_count;
  reg [5:0] div_count;
  reg samp_tick;
  reg [1:0] slot_sel;
  reg evt_meta;
  reg evt_sync;
  reg evt_prev;
  reg evt_pend;
  reg lpm_meta;
  reg lpm_sync;
  // divide ratio lookup
  function [5:0] div_ratio;
    input [2:0] code;
    begin
      case (code)
        3'h0: div_ratio = 6'd1;
        3'h1: div_ratio = 6'd2;
        3'h2: div_ratio = 6'd4;
        3'h3: div_ratio = 6'd8;
        3'h4: div_ratio = 6'd16;
        3'h5: div_ratio = 6'd24;
        3'h6: div_ratio = 6'd32;
        default: div_ratio = 6'd48;
      endcase
    end
  endfunction
  // conversion length lookup
  function [4:0] conv_len;
    input [1:0] depth;
    begin
      case (depth)
        2'h1: conv_len = `CONV_CYC_10;
        2'h2: conv_len = `CONV_CYC_8;
        default: conv_len = `CONV_CYC_12;
      endcase
    end
  endfunction
  // sample clock enable pulse
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_count <= 6'h00;
      samp_tick <= 1'b0;
    end else if (div_count >= div_ratio(sample_clock_divider) - 6'd1) begin
      div_count <= 6'h00;
      samp_tick <= 1'b1;
    end else begin
      div_count <= div_count + 6'd1;
      samp_tick <= 1'b0;
    end
  end
  // synchronisers for pins
  always @(posedge aclk) begin
    if (!aresetn) begin
      evt_meta <= 1'b0;
      evt_sync <= 1'b0;
      evt_prev <= 1'b0;
      lpm_meta <= 1'b0;
      lpm_sync <= 1'b0;
    end else begin
      evt_meta <= event_trigger;
      evt_sync <= evt_meta;
      evt_prev <= evt_sync;
      lpm_meta <= low_power_mode;
      lpm_sync <= lpm_meta;
    end
  end

  wire evt_rise = evt_sync & ~evt_prev;
  wire sw_trig = ~trigger_origin_bit & start_conversion_bit;
  wire hw_trig = trigger_origin_bit & (evt_rise | evt_pend);
  wire trig = conversion_enable_bit & ~lpm_sync & (sw_trig | hw_trig);
  wire [9:0] cmp_sel = slot_cfg[slot_sel][`F_TIME_PICK] ? compare_one : compare_zero;
  wire launch = (state == ST_IDLE) & trig & (sampling_style_bit | samp_tick);
  // axi handshake
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg ar_pend;
  reg [7:0] ar_addr;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~ar_pend & ~s_axi_rvalid;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ok = (aw_addr <= `OFS_RESULT_BASE + 8'h0c);
  wire [1:0] res_rd_addr = (s_axi_arvalid & s_axi_arready) ? s_axi_araddr[3:2] : ar_addr[3:2];
  wire [15:0] res_rd_data;
  wire res_wr = (state == ST_CONV) & core_done;

  result_store u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(res_wr),
    .wr_addr(slot_sel),
    .wr_data(core_result),
    .rd_addr(res_rd_addr),
    .rd_data(res_rd_data)
  );

  // register writes and control sequencing
  integer k;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      power_policy_bit <= 1'b0;
      sample_clock_divider <= 3'h0;
      conversion_enable_bit <= 1'b0;
      start_conversion_bit <= 1'b0;
      trigger_origin_bit <= 1'b0;
      sampling_style_bit <= 1'b0;
      bit_depth_select <= `RST_DEPTH;
      clock_origin_field <= 2'h0;
      compare_zero <= `RST_COMPARE;
      compare_one <= `RST_COMPARE;
      for (k = 0; k < 4; k = k + 1) begin
        slot_cfg[k] <= 3'h0;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      // auto launch consumes start bit; a same-cycle software write wins below
      if (launch && !sampling_style_bit) start_conversion_bit <= 1'b0;
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
        if (w_strb[0]) begin
          case (aw_addr)
            `OFS_CONTROL_ZERO: begin
              power_policy_bit <= w_data[`F_POWER_POLICY];
              sample_clock_divider <= w_data[`F_DIVIDER_HI:`F_DIVIDER_LO];
            end
            `OFS_CONTROL_ONE: begin
              conversion_enable_bit <= w_data[`F_ENABLE];
              start_conversion_bit <= w_data[`F_START];
              trigger_origin_bit <= w_data[`F_TRIG_ORIGIN];
              sampling_style_bit <= w_data[`F_SAMP_STYLE];
            end
            `OFS_CONTROL_TWO: bit_depth_select <= w_data[`F_DEPTH_HI:`F_DEPTH_LO];
            `OFS_CLOCK_SOURCE: clock_origin_field <= w_data[1:0];
            `OFS_SLOT_BASE, `OFS_SLOT_BASE + 8'h04, `OFS_SLOT_BASE + 8'h08,
            `OFS_SLOT_BASE + 8'h0c: slot_cfg[aw_addr[3:2]] <= w_data[2:0];
            default: ;
          endcase
        end
        if (aw_addr == `OFS_COMPARE_ZERO) begin
          if (w_strb[0]) compare_zero[7:0] <= w_data[7:0];
          if (w_strb[1]) compare_zero[9:8] <= w_data[9:8];
        end
        if (aw_addr == `OFS_COMPARE_ONE) begin
          if (w_strb[0]) compare_one[7:0] <= w_data[7:0];
          if (w_strb[1]) compare_one[9:8] <= w_data[9:8];
        end
      end
    end
  end

  // sample and conversion sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      sample_timer <= 10'h000;
      conv_count <= 5'h00;
      sync_count <= 2'h0;
      slot_sel <= 2'h0;
      sample <= 1'b0;
      convert <= 1'b0;
      module_enable <= 1'b0;
      conv_bit_depth <= `RST_DEPTH;
      reference_pick <= 2'h0;
      active_slot <= 2'h0;
      evt_pend <= 1'b0;
    end else if (lpm_sync) begin
      state <= ST_IDLE;
      sample <= 1'b0;
      convert <= 1'b0;
      module_enable <= 1'b0;
    end else begin
      // an event edge seen while idle waits for the next sample clock tick
      evt_pend <= (evt_pend | evt_rise) & trigger_origin_bit & conversion_enable_bit &
                  (state == ST_IDLE) & ~launch;
      case (state)
        ST_IDLE: begin
          if (launch) begin
            sample <= 1'b1;
            sample_timer <= 10'h000;
            conv_bit_depth <= (bit_depth_select == 2'h3) ? `RST_DEPTH : bit_depth_select;
            reference_pick <= slot_cfg[slot_sel][`F_REF_HI:`F_REF_LO];
            active_slot <= slot_sel;
            state <= sampling_style_bit ? ST_SAMP : ST_WAKE;
          end else if (!power_policy_bit && !trig) begin
            module_enable <= 1'b0;
          end else begin
            module_enable <= conversion_enable_bit;
          end
        end
        ST_WAKE: begin
          if (samp_tick) begin
            module_enable <= 1'b1;
            state <= ST_SAMP;
          end
        end
        ST_SAMP: begin
          if (sampling_style_bit) begin
            module_enable <= 1'b1;
            if (!start_conversion_bit) begin
              sample <= 1'b0;
              sync_count <= 2'h0;
              state <= ST_SYNC;
            end
          end else if (samp_tick) begin
            if (sample_timer >= cmp_sel) begin
              sample <= 1'b0;
              convert <= 1'b1;
              conv_count <= 5'h00;
              state <= ST_CONV;
            end else begin
              sample_timer <= sample_timer + 10'd1;
            end
          end
        end
        ST_SYNC: begin
          if (sync_count == `MANUAL_SYNC_CYC - 2'd1) begin
            convert <= 1'b1;
            conv_count <= 5'h00;
            state <= ST_CONV;
          end else begin
            sync_count <= sync_count + 2'd1;
          end
        end
        ST_CONV: begin
          if (conv_count == conv_len(conv_bit_depth) - 5'd1) begin
            convert <= 1'b0;
            state <= ST_IDLE;
            if (!power_policy_bit && !trig) begin
              module_enable <= 1'b0;
            end
          end else begin
            conv_count <= conv_count + 5'd1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // read path; the result store is addressed as the request is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      ar_pend <= 1'b0;
      ar_addr <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_pend <= 1'b1;
        ar_addr <= s_axi_araddr;
      end
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (ar_pend) begin
        ar_pend <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (ar_addr)
          `OFS_CONTROL_ZERO: s_axi_rdata <= {28'h0, sample_clock_divider, power_policy_bit};
          `OFS_CONTROL_ONE: s_axi_rdata <= {28'h0, sampling_style_bit, trigger_origin_bit,
                                            start_conversion_bit, conversion_enable_bit};
          `OFS_CONTROL_TWO: s_axi_rdata <= {29'h0, bit_depth_select, 1'b0};
          `OFS_CLOCK_SOURCE: s_axi_rdata <= {30'h0, clock_origin_field};
          `OFS_COMPARE_ZERO: s_axi_rdata <= {22'h0, compare_zero};
          `OFS_COMPARE_ONE: s_axi_rdata <= {22'h0, compare_one};
          `OFS_STATUS: s_axi_rdata <= {29'h0, sample, module_enable, state != ST_IDLE};
          `OFS_SLOT_BASE, `OFS_SLOT_BASE + 8'h04, `OFS_SLOT_BASE + 8'h08,
          `OFS_SLOT_BASE + 8'h0c: s_axi_rdata <= {29'h0, slot_cfg[ar_addr[3:2]]};
          `OFS_RESULT_BASE, `OFS_RESULT_BASE + 8'h04, `OFS_RESULT_BASE + 8'h08,
          `OFS_RESULT_BASE + 8'h0c: s_axi_rdata <= {16'h0, res_rd_data};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- conv_ctrl_props.sv
// Purpose: port checks for the converter control block
// Assumes: one clock domain, sync active-low reset
// Notes: bound into conv_ctrl after the module
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // chip power state
  input wire logic low_power_mode,
  // analog core side
  input wire logic module_enable,
  input wire logic sample,
  input wire logic convert,
  input wire logic [1:0] conv_bit_depth,
  input wire logic [1:0] reference_pick
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // cycles the present conversion window has stood
  logic [4:0] cnt;
  always @(posedge aclk) begin
    if (!aresetn || !convert) begin
      cnt <= 5'h00;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end
  depth_legal_a: assert property (conv_bit_depth != 2'h3)
    else $error("bit depth code out of range");
  conv_length_a: assert property ($fell(convert) && $past(aresetn) && !$past(low_power_mode, 3) |->
    cnt == (conv_bit_depth == 2'h0 ? 5'h0e : conv_bit_depth == 2'h1 ? 5'h0c : 5'h09))
    else $error("conversion window length wrong");
  depth_hold_a: assert property (convert && $past(convert) |->
    $stable(conv_bit_depth))
    else $error("bit depth changed in conversion");
  ref_hold_a: assert property (convert && $past(convert) |->
    $stable(reference_pick))
    else $error("reference changed in conversion");
  phase_apart_a: assert property (!(sample && convert))
    else $error("sample and convert overlap");
  powered_conv_a: assert property (convert |-> module_enable)
    else $error("conversion without module enable");
  wake_up_a: assert property ($rose(sample) && !low_power_mode |->
    ##[0:100] module_enable)
    else $error("module enable late after sample");
  standby_idle_a: assert property (low_power_mode [*4] |-> !sample && !convert)
    else $error("converter active in standby");
endmodule
bind conv_ctrl conv_ctrl_props u_props (.aclk, .aresetn, .low_power_mode, .module_enable,
  .sample, .convert, .conv_bit_depth, .reference_pick);
`default_nettype wire

//--- sar_core_model.sv
// Purpose: behavioural SAR core facing the control block
// Assumes: convert stands for a whole conversion window
// Notes: one done pulse per window, early or late by slow
`timescale 1ns/1ps
`default_nettype none
module sar_core_model (
  // clock and pace
  input wire logic aclk,
  input wire logic slow,
  // control from the block
  input wire logic module_enable,
  input wire logic convert,
  // answer to the block
  output logic core_done,
  output logic [15:0] core_result
);
  logic [3:0] cyc;
  logic [15:0] code;
  initial begin
    core_done = 1'b0;
    core_result = 16'h0000;
    cyc = 4'h0;
    code = 16'h0a50;
  end
  always @(posedge aclk) begin
    core_done <= 1'b0;
    // result bus holds no stale value outside the pulse
    core_result <= ~core_result;
    cyc <= convert ? cyc + 4'h1 : 4'h0;
    // an unpowered core never answers
    if (convert && module_enable && cyc == (slow ? 4'h7 : 4'h1)) begin
      core_done <= 1'b1;
      core_result <= code;
      code <= code + 16'h0111;
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench for the converter control block
// Assumes: offsets and fields from conv_ctrl_map.vh
// Notes: registers over AXI4-Lite; analog core is a model
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_map.vh"
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, event_trigger, low_power_mode, slow;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd;
  logic [3:0] s_axi_wstrb, rp;
  logic [15:0] last_res;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire module_enable, sample, convert, core_done;
  wire [1:0] s_axi_bresp, s_axi_rresp, conv_bit_depth, reference_pick;
  wire [1:0] clock_origin_field, active_slot;
  wire [31:0] s_axi_rdata;
  wire [15:0] core_result;
  int n_errors, compares, n, c, k, cyc, t_fall, lat;
  int m[5];
  conv_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .event_trigger, .low_power_mode, .module_enable, .sample, .convert,
    .conv_bit_depth, .reference_pick, .clock_origin_field, .active_slot, .core_done,
    .core_result);
  sar_core_model core (.aclk, .slow, .module_enable, .convert, .core_done, .core_result);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (core_done) last_res <= core_result;
  end
  always @(negedge sample) t_fall = cyc;
  always @(posedge convert) lat = cyc - t_fall;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int w;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    w = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      w++;
    end while (!s_axi_bvalid && w < 200);
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [1:0] er = 2'h0);
    int w;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    w = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      w++;
    end while (!s_axi_rvalid && w < 200);
    rd = s_axi_rdata;
    chk({s_axi_rvalid, s_axi_rresp}, {1'b1, er});
  endtask
  // length in cycles of the next sample or convert window
  task automatic hi_len(input bit cv);
    n = 0;
    while (!(cv ? convert : sample) && n < 500) begin
      @(posedge aclk);
      n++;
    end
    rp = {conv_bit_depth, reference_pick};
    n = 0;
    while ((cv ? convert : sample) && n < 200) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic rises(input int cycles);
    logic p;
    c = 0;
    p = sample;
    repeat (cycles) begin
      @(posedge aclk);
      if (sample && !p) c++;
      p = sample;
    end
  endtask
  task automatic run_conv(input logic [1:0] dep, input logic pol);
    wr(`OFS_CONTROL_ZERO, {31'h0, pol});
    wr(`OFS_CONTROL_TWO, {29'h0, dep, 1'b0});
    wr(`OFS_SLOT_BASE, {30'h0, dep});
    slow <= dep[0];
    wr(`OFS_CONTROL_ONE, 32'h3);
    hi_len(1'b1);
    chk(n, dep == 2'h0 ? 14 : dep == 2'h1 ? 12 : 9);
    chk(rp, {dep, dep});
    chk(active_slot, 2'h0);
    rd_reg(`OFS_RESULT_BASE);
    chk(rd, {16'h0, last_res});
    rd_reg(`OFS_CONTROL_ONE);
    chk(rd[1], 1'b0);
    chk(module_enable, pol);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    final_report;
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, event_trigger, low_power_mode, slow} = 6'h00;
    {s_axi_bready, s_axi_rready} = 2'h3;
    s_axi_wstrb = 4'hf;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({module_enable, sample, convert, conv_bit_depth, reference_pick}, 0);
    for (k = 0; k < 16; k++) begin
      if (k != 7) begin
        rd_reg(8'(k * 4));
        chk(rd, 0);
      end
    end
    rd_reg(8'h40, 2'h2);
    chk(rd, 0);
    wr(8'hf0, 32'h1, 2'h2);
    $display("reset and map test done");
    wr(`OFS_CONTROL_ONE, 32'h2);
    rises(60);
    chk(c, 0);
    wr(`OFS_CONTROL_ONE, 32'h0);
    for (k = 0; k < 3; k++) run_conv(k[1:0], 1'b0);
    run_conv(2'h0, 1'b1);
    run_conv(2'h2, 1'b0);
    wr(`OFS_CLOCK_SOURCE, 32'h1);
    rd_reg(`OFS_CLOCK_SOURCE);
    chk(rd, 1);
    chk(clock_origin_field, 1);
    $display("conversion test done");
    wr(`OFS_COMPARE_ZERO, 32'h3);
    wr(`OFS_COMPARE_ONE, 32'ha);
    for (k = 0; k < 5; k++) begin
      wr(`OFS_CONTROL_ZERO, {28'h0, 3'(k > 2), 1'b0});
      wr(`OFS_SLOT_BASE, {29'h0, k == 1 || k == 3, 2'h0});
      wr(`OFS_CONTROL_ONE, 32'h3);
      hi_len(1'b0);
      m[k] = n;
      hi_len(1'b1);
    end
    chk(m[1] - m[0], 7);
    chk(m[2], m[0]);
    chk(m[3] - m[4], 14);
    $display("sample timer test done");
    wr(`OFS_CONTROL_ZERO, 32'h0);
    wr(`OFS_CONTROL_ONE, 32'h5);
    event_trigger <= 1'b1;
    rises(150);
    chk(c, 1);
    event_trigger <= 1'b0;
    wr(`OFS_CONTROL_ONE, 32'h1);
    $display("event trigger test done");
    low_power_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(`OFS_CONTROL_ONE, 32'h3);
    rises(60);
    chk(c, 0);
    wr(`OFS_CONTROL_ONE, 32'h1);
    low_power_mode <= 1'b0;
    $display("standby test done");
    wr(`OFS_CONTROL_ONE, 32'hb);
    rises(30);
    chk(c, 1);
    chk(sample, 1'b1);
    wr(`OFS_CONTROL_ONE, 32'h9);
    repeat (30) @(posedge aclk);
    chk(lat >= 2 && lat <= 3, 1);
    $display("manual sampling test done");
    final_report;
  end
endmodule
`default_nettype wire
